// ### design/mcp_pwm_top.sv
/*
 * Multichannel PWM control: decodes 16-bit serial frames into per-channel
 * duty, phase, on/off and divider settings, a shared duty value, counter
 * sync and saturating step frames, and drives six PWM outputs.
 * Assumes fail_mode comes from logic on core_clk; pins are synchronised.
 */
`timescale 1ns/1ps
`default_nettype none
module mcp_pwm_top
    import mcp_pkg::*;
#(
    parameter int SLOW_LIMIT_CYC = SLOW_LIMIT_CYC_DEF
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic chip_select_n,
    input wire logic spi_clk,
    input wire logic spi_data_in,
    input wire logic pwm_clk_in,
    input wire logic fail_mode,
    output logic [NCH-1:0] output_drive,
    output logic [NCH-1:0] fast_edge,
    output logic clock_fail,
    output logic watchdog_toggle_bit
);
    mcp_frame_if fif ();

    logic frm_valid;
    logic [FRAME_BITS-1:0] frm_data;
    logic [ADDR_W-1:0] frm_addr;
    logic [CH_IDX_W-1:0] ch_idx;
    logic ch_hit;
    logic init_hit;
    logic outctl_hit;
    logic glob_hit;
    logic prs_hit;
    logic incr_hit;
    logic sync_req;
    logic ext_tick;
    logic pwm_hold;

    logic [DUTY_W-1:0] duty_r [NCH];
    logic [PH_W-1:0] phase_r [NCH];
    logic [NCH-1:0] on_r;
    logic [NCH-1:0] shared_duty_select_r;
    logic [DUTY_W-1:0] shared_duty_value_r;
    logic [NCH-1:0] divider_code_lo_r;
    logic [NCH-1:0] divider_code_hi_r;
    logic watchdog_r;
    logic [CNT_W-1:0] pwm_cnt_r;
    logic [NCH-1:0] output_drive_r;
    logic [NCH-1:0] output_drive_nxt;

    // saturating step of one duty value
    function automatic logic [DUTY_W-1:0] sat_step(
        input logic [DUTY_W-1:0] d,
        input logic [INC_CODE_W-1:0] code,
        input logic up
    );
        logic [DUTY_W:0] sum;
        logic [DUTY_W-1:0] step;
        logic [DUTY_W-1:0] res;
        unique case (code)
            INC_NONE: step = DUTY_MIN;
            INC_4: step = STEP_4;
            INC_8: step = STEP_8;
            INC_16: step = STEP_16;
        endcase
        if (up) begin
            sum = {1'b0, d} + {1'b0, step};
            res = sum[DUTY_W] ? DUTY_MAX : sum[DUTY_W-1:0];
        end else begin
            sum = {1'b0, d} - {1'b0, step};
            res = sum[DUTY_W] ? DUTY_MIN : sum[DUTY_W-1:0];
        end
        return res;
    endfunction

    // position of a channel inside its own period, phase removed
    function automatic logic [DUTY_W-1:0] chan_pos(
        input logic [CNT_W-1:0] cnt,
        input logic code_hi,
        input logic code_lo,
        input logic [PH_W-1:0] ph
    );
        logic [DUTY_W-1:0] p;
        if (code_hi)
            p = DUTY_W'(cnt >> DIV1_SHIFT);
        else if (code_lo)
            p = DUTY_W'(cnt >> DIV2_SHIFT);
        else
            p = DUTY_W'(cnt >> DIV4_SHIFT);
        return DUTY_W'(p - {ph, PHASE_PAD});
    endfunction

    mcp_spi_rx u_rx (
        .core_clk(core_clk),
        .resetn(resetn),
        .chip_select_n(chip_select_n),
        .spi_clk(spi_clk),
        .spi_data_in(spi_data_in),
        .frm(fif.rx)
    );

    mcp_clk_mon #(
        .SLOW_CYC(SLOW_LIMIT_CYC)
    ) u_mon (
        .core_clk(core_clk),
        .resetn(resetn),
        .pwm_clk_in(pwm_clk_in),
        .ext_tick(ext_tick),
        .clock_fail(clock_fail)
    );

    // frames arrive only at chip select release
    // frame end apply
    assign frm_valid = fif.valid;
    assign frm_data = fif.data;
    assign frm_addr = frm_data[F_ADDR_LO +: ADDR_W];
    assign ch_idx = CH_IDX_W'(frm_addr - ADDR_CH_FIRST);
    assign ch_hit = frm_valid && frm_addr >= ADDR_CH_FIRST
        && frm_addr <= ADDR_CH_LAST;
    assign init_hit = frm_valid && frm_addr == ADDR_INIT;
    assign outctl_hit = frm_valid && frm_addr == ADDR_OUTCTL;
    assign glob_hit = frm_valid && frm_addr == ADDR_GLOBAL;
    assign prs_hit = frm_valid && frm_addr == ADDR_PRESCALE;
    assign incr_hit = frm_valid && frm_addr == ADDR_INCR;
    assign sync_req = init_hit && frm_data[F_SYNC];

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < NCH; i++)
                duty_r[i] <= DUTY_RST;
        end else if (ch_hit) begin
            duty_r[ch_idx] <= frm_data[DUTY_W-1:0];
        end else if (incr_hit) begin
            for (int i = 0; i < NINT; i++)
                duty_r[i] <= sat_step(duty_r[i],
                    frm_data[INC_CODE_W*i +: INC_CODE_W],
                    frm_data[F_SIGN]);
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < NCH; i++)
                phase_r[i] <= PH_RST;
        end else if (ch_hit) begin
            phase_r[ch_idx] <= frm_data[F_PH_LO +: PH_W];
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            on_r <= MASK_RST;
        else if (ch_hit)
            on_r[ch_idx] <= frm_data[F_ON];
        else if (outctl_hit)
            on_r <= frm_data[NCH-1:0];
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            shared_duty_select_r <= MASK_RST;
            shared_duty_value_r <= DUTY_RST;
        end else if (glob_hit && !frm_data[F_BANK]) begin
            shared_duty_select_r <= frm_data[NCH-1:0];
        end else if (glob_hit) begin
            shared_duty_value_r <= frm_data[DUTY_W-1:0];
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            divider_code_lo_r <= MASK_RST;
            divider_code_hi_r <= MASK_RST;
        end else if (prs_hit && !frm_data[F_BANK]) begin
            divider_code_lo_r <= frm_data[NCH-1:0];
        end else if (prs_hit) begin
            divider_code_hi_r <= frm_data[NCH-1:0];
        end
    end

    // last watchdog bit seen in any frame
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            watchdog_r <= 1'b0;
        else if (frm_valid)
            watchdog_r <= frm_data[F_WD];
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            pwm_cnt_r <= '0;
        else if (sync_req)
            pwm_cnt_r <= '0;
        else if (ext_tick)
            pwm_cnt_r <= CNT_W'(pwm_cnt_r + 1'b1);
    end

    assign pwm_hold = clock_fail || fail_mode;

    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            logic [DUTY_W-1:0] eff;
            eff = shared_duty_select_r[i] ? shared_duty_value_r : duty_r[i];
            if (!on_r[i])
                output_drive_nxt[i] = 1'b0;
            else if (pwm_hold)
                output_drive_nxt[i] = 1'b1;
            else
                output_drive_nxt[i] = chan_pos(pwm_cnt_r,
                    divider_code_hi_r[i], divider_code_lo_r[i],
                    phase_r[i]) < eff;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            output_drive_r <= MASK_RST;
        else
            output_drive_r <= output_drive_nxt;
    end

    assign output_drive = output_drive_r;
    assign fast_edge = divider_code_hi_r;
    assign watchdog_toggle_bit = watchdog_r;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    property p_sync_reset;
        sync_req |=> pwm_cnt_r == '0;
    endproperty
    a_sync_reset: assert property (p_sync_reset)
        else $error("pwm counter not cleared by sync frame");

    property p_no_sync;
        (init_hit && !frm_data[F_SYNC] && !ext_tick)
            |=> pwm_cnt_r == $past(pwm_cnt_r);
    endproperty
    a_no_sync: assert property (p_no_sync)
        else $error("pwm counter disturbed without sync bit");

    property p_hold_full;
        pwm_hold |=> output_drive == $past(on_r);
    endproperty
    a_hold_full: assert property (p_hold_full)
        else $error("outputs switching while held");

    property p_off_low;
        on_r == MASK_RST |=> output_drive == MASK_RST;
    endproperty
    a_off_low: assert property (p_off_low)
        else $error("switched-off channel driven");

    property p_ch_write;
        (ch_hit && frm_addr == ADDR_CH_FIRST)
            |=> duty_r[0] == $past(frm_data[DUTY_W-1:0])
            && on_r[0] == $past(frm_data[F_ON]);
    endproperty
    a_ch_write: assert property (p_ch_write)
        else $error("channel frame not stored");

    property p_glob_duty;
        (glob_hit && frm_data[F_BANK])
            |=> shared_duty_value_r == $past(frm_data[DUTY_W-1:0]);
    endproperty
    a_glob_duty: assert property (p_glob_duty)
        else $error("shared duty not stored");

    property p_keep_ext;
        incr_hit |=> duty_r[NCH-1] == $past(duty_r[NCH-1])
            && shared_duty_value_r == $past(shared_duty_value_r);
    endproperty
    a_keep_ext: assert property (p_keep_ext)
        else $error("step frame changed excluded duty");

    property p_step_up4;
        (incr_hit && frm_data[F_SIGN]
            && frm_data[INC_CODE_W-1:0] == INC_4
            && duty_r[0] <= DUTY_MAX - STEP_4)
            |=> duty_r[0] == DUTY_W'($past(duty_r[0]) + STEP_4);
    endproperty
    a_step_up4: assert property (p_step_up4)
        else $error("increment by four wrong");

    property p_sat_top;
        (incr_hit && frm_data[F_SIGN] && duty_r[0] == DUTY_MAX)
            |=> duty_r[0] == DUTY_MAX;
    endproperty
    a_sat_top: assert property (p_sat_top)
        else $error("duty wrapped above FF");

    property p_sat_bottom;
        (incr_hit && !frm_data[F_SIGN] && duty_r[1] == DUTY_MIN)
            |=> duty_r[1] == DUTY_MIN;
    endproperty
    a_sat_bottom: assert property (p_sat_bottom)
        else $error("duty wrapped below 00");

    c_sync: cover property (sync_req);
    c_incr: cover property (incr_hit ##[1:1000] incr_hit);
    c_fail: cover property ($rose(clock_fail) && on_r != MASK_RST);
endmodule
`default_nettype wire

// ### design/mcp_pkg.sv
/*
 * Shared constants for the multichannel PWM control block: frame layout,
 * register addresses, reset values and clock supervision limits.
 * Assumes a 125 MHz core clock and 16-bit serial frames, MSB first.
 */
package mcp_pkg;
    localparam int NCH = 6;
    localparam int NINT = 5;
    localparam int FRAME_BITS = 16;
    localparam int ADDR_W = 4;
    localparam int DUTY_W = 8;
    localparam int PH_W = 2;
    localparam int CH_IDX_W = 3;
    localparam int INC_CODE_W = 2;
    localparam int BITCNT_W = 5;
    localparam int CNT_W = 10;
    localparam int MON_W = 17;

    // frame field positions
    localparam int F_ADDR_LO = 12;
    localparam int F_WD = 11;
    localparam int F_BANK = 10;
    localparam int F_SIGN = 10;
    localparam int F_PH_LO = 9;
    localparam int F_ON = 8;
    localparam int F_SYNC = 1;

    // register addresses carried in the frame
    localparam logic [ADDR_W-1:0] ADDR_INIT = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_CH_FIRST = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_CH_LAST = 4'h7;
    localparam logic [ADDR_W-1:0] ADDR_OUTCTL = 4'h8;
    localparam logic [ADDR_W-1:0] ADDR_GLOBAL = 4'h9;
    localparam logic [ADDR_W-1:0] ADDR_PRESCALE = 4'hC;
    localparam logic [ADDR_W-1:0] ADDR_INCR = 4'hE;

    localparam logic [DUTY_W-1:0] DUTY_RST = 8'h00;
    localparam logic [DUTY_W-1:0] DUTY_MIN = 8'h00;
    localparam logic [DUTY_W-1:0] DUTY_MAX = 8'hFF;
    localparam logic [NCH-1:0] MASK_RST = 6'h00;
    localparam logic [PH_W-1:0] PH_RST = 2'h0;
    localparam logic [5:0] PHASE_PAD = 6'h00;

    // step codes and sizes of the incremental frame
    localparam logic [INC_CODE_W-1:0] INC_NONE = 2'h0;
    localparam logic [INC_CODE_W-1:0] INC_4 = 2'h1;
    localparam logic [INC_CODE_W-1:0] INC_8 = 2'h2;
    localparam logic [INC_CODE_W-1:0] INC_16 = 2'h3;
    localparam logic [DUTY_W-1:0] STEP_4 = 8'h04;
    localparam logic [DUTY_W-1:0] STEP_8 = 8'h08;
    localparam logic [DUTY_W-1:0] STEP_16 = 8'h10;

    // counter shift per divider: div1, div2, div4
    localparam int DIV1_SHIFT = 0;
    localparam int DIV2_SHIFT = 1;
    localparam int DIV4_SHIFT = 2;

    // external clock supervision
    localparam int CLK_PERIOD_NS = 8;
    localparam int FAST_LIMIT_NS = 4883;
    localparam int SLOW_LIMIT_NS = 78125;
    localparam int FAST_LIMIT_CYC =
        (FAST_LIMIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SLOW_LIMIT_CYC_DEF = SLOW_LIMIT_NS / CLK_PERIOD_NS;
endpackage

// ### design/mcp_frame_if.sv
/*
 * Carries one received 16-bit frame from the serial receiver to the core.
 * Assumes both ends run on core_clk; valid is a one-cycle pulse.
 */
`timescale 1ns/1ps
`default_nettype none
interface mcp_frame_if;
    import mcp_pkg::*;
    logic valid;
    logic [FRAME_BITS-1:0] data;
    modport rx (output valid, output data);
    modport core (input valid, input data);
endinterface
`default_nettype wire

// ### design/mcp_spi_rx.sv
/*
 * Serial frame receiver: samples the pins through synchronisers, shifts
 * data MSB first on falling serial clock edges, and hands over a frame
 * at the rising edge of chip select when exactly 16 bits were seen.
 * Assumes serial clock well below a quarter of core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module mcp_spi_rx
    import mcp_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic chip_select_n,
    input wire logic spi_clk,
    input wire logic spi_data_in,
    mcp_frame_if.rx frm
);
    logic [2:0] cs_s_r;
    logic [2:0] sck_s_r;
    logic [1:0] sdi_s_r;
    logic [FRAME_BITS-1:0] shift_r;
    logic [BITCNT_W-1:0] bitcnt_r;
    logic sck_fall;
    logic cs_rise;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cs_s_r <= 3'h7;
            sck_s_r <= 3'h0;
            sdi_s_r <= 2'h0;
        end else begin
            cs_s_r <= {cs_s_r[1:0], chip_select_n};
            sck_s_r <= {sck_s_r[1:0], spi_clk};
            sdi_s_r <= {sdi_s_r[0], spi_data_in};
        end
    end

    assign sck_fall = !sck_s_r[1] && sck_s_r[2] && !cs_s_r[1];
    assign cs_rise = cs_s_r[1] && !cs_s_r[2];

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            shift_r <= '0;
            bitcnt_r <= '0;
        end else if (cs_s_r[1]) begin
            bitcnt_r <= '0;
        end else if (sck_fall) begin
            shift_r <= {shift_r[FRAME_BITS-2:0], sdi_s_r[1]};
            if (bitcnt_r <= BITCNT_W'(FRAME_BITS))
                bitcnt_r <= bitcnt_r + 1'b1;
        end
    end

    // frames of any other length are dropped
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            frm.valid <= 1'b0;
            frm.data <= '0;
        end else begin
            frm.valid <= cs_rise && bitcnt_r == BITCNT_W'(FRAME_BITS);
            if (cs_rise)
                frm.data <= shift_r;
        end
    end
endmodule
`default_nettype wire

// ### design/mcp_clk_mon.sv
/*
 * External PWM clock supervisor: synchronises the clock pin, emits one
 * tick per rising edge and flags the clock as failed when an interval is
 * too short or grows too long. Assumes core_clk far above the pin rate.
 */
`timescale 1ns/1ps
`default_nettype none
module mcp_clk_mon
    import mcp_pkg::*;
#(
    parameter int SLOW_CYC = SLOW_LIMIT_CYC_DEF
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic pwm_clk_in,
    output logic ext_tick,
    output logic clock_fail
);
    logic [2:0] clk_s_r;
    logic [MON_W-1:0] ivl_r;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            clk_s_r <= 3'h0;
        else
            clk_s_r <= {clk_s_r[1:0], pwm_clk_in};
    end

    assign ext_tick = clk_s_r[1] && !clk_s_r[2];

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            ivl_r <= '0;
        else if (ext_tick)
            ivl_r <= '0;
        else if (ivl_r < MON_W'(SLOW_CYC))
            ivl_r <= ivl_r + 1'b1;
    end

    // failed until a good interval proves the clock
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            clock_fail <= 1'b1;
        else if (ext_tick)
            // an edge after a timed-out gap is not a good interval
            clock_fail <= ivl_r < MON_W'(FAST_LIMIT_CYC)
                || ivl_r >= MON_W'(SLOW_CYC);
        else if (ivl_r >= MON_W'(SLOW_CYC))
            clock_fail <= 1'b1;
    end

    property p_slow_fail;
        @(posedge core_clk) disable iff (!resetn)
        (ivl_r == MON_W'(SLOW_CYC) && !ext_tick) |=> clock_fail;
    endproperty
    a_slow_fail: assert property (p_slow_fail)
        else $error("slow external clock not flagged");

    property p_fast_fail;
        @(posedge core_clk) disable iff (!resetn)
        (ext_tick && ivl_r < MON_W'(FAST_LIMIT_CYC)) |=> clock_fail;
    endproperty
    a_fast_fail: assert property (p_fast_fail)
        else $error("fast external clock not flagged");
endmodule
`default_nettype wire

// ### dv/mcp_host_model.sv
/*
 * Host model: a serial bus master that sends 16-bit frames MSB first, or only the top 15 bits when whole is clear.
 * Assumes the bench calls send on a falling core_clk edge.
 */
`timescale 1ns/1ps
`default_nettype none
module mcp_host_model (
    input wire logic core_clk,
    output logic chip_select_n,
    output logic spi_clk,
    output logic spi_data_in
);
    initial begin
        chip_select_n = 1'b1;
        spi_clk = 1'b0;
        spi_data_in = 1'b0;
    end

    task automatic send(input logic [15:0] v, input logic whole);
        int n;
        n = whole ? 16 : 15;
        @(negedge core_clk);
        chip_select_n = 1'b0;
        for (int i = 15; i > 15 - n; i--) begin
            repeat (4) @(negedge core_clk);
            spi_data_in = v[i];
            repeat (4) @(negedge core_clk);
            spi_clk = 1'b1;
            repeat (4) @(negedge core_clk);
            spi_clk = 1'b0;
        end
        repeat (4) @(negedge core_clk);
        chip_select_n = 1'b1;
        // released line shows the inverse of the last bit
        spi_data_in = ~spi_data_in;
    endtask
endmodule
`default_nettype wire

// ### dv/mcp_pwm_top_tb.sv
/*
 * Self-checking bench for mcp_pwm_top against a behavioural model.
 * Assumes the design files and the host model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module mcp_pwm_top_tb;
    import mcp_pkg::*;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic pwm_clk_in = 1'b0;
    logic fail_mode = 1'b0;
    logic pwm_run = 1'b0;
    wire logic chip_select_n;
    wire logic spi_clk;
    wire logic spi_data_in;
    logic [NCH-1:0] output_drive;
    logic [NCH-1:0] fast_edge;
    logic clock_fail;
    logic watchdog_toggle_bit;
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int seed = 32'hc117d8ae;
    int duty[NCH];
    int ph[NCH];
    int gduty = 0;
    int cnt = 0;
    int r;
    int a;
    int addrs[11] = '{1, 2, 3, 4, 5, 6, 7, 8, 9, 12, 14};
    logic [NCH-1:0] on_m = 6'h00;
    logic [NCH-1:0] gsel = 6'h00;
    logic [NCH-1:0] dlo = 6'h00;
    logic [NCH-1:0] dhi = 6'h00;
    logic wd_m = 1'b0;
    logic cf_m = 1'b1;
    logic [15:0] f;

    mcp_host_model host (
        .core_clk(core_clk),
        .chip_select_n(chip_select_n),
        .spi_clk(spi_clk),
        .spi_data_in(spi_data_in)
    );

    mcp_pwm_top #(.SLOW_LIMIT_CYC(700)) dut (
        .core_clk(core_clk),
        .resetn(resetn),
        .chip_select_n(chip_select_n),
        .spi_clk(spi_clk),
        .spi_data_in(spi_data_in),
        .pwm_clk_in(pwm_clk_in),
        .fail_mode(fail_mode),
        .output_drive(output_drive),
        .fast_edge(fast_edge),
        .clock_fail(clock_fail),
        .watchdog_toggle_bit(watchdog_toggle_bit)
    );

    initial begin
        forever #4 core_clk = ~core_clk;
    end

    // external clock, 640 core cycles a period while running
    initial begin
        forever begin
            if (pwm_run) begin
                repeat (320) @(negedge core_clk);
                pwm_clk_in = ~pwm_clk_in;
            end else begin
                @(negedge core_clk);
                pwm_clk_in = 1'b0;
            end
        end
    end

    always @(posedge pwm_clk_in) cnt = (cnt + 1) % 1024;

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            n_errors++;
            conclude();
        end
    end

    function automatic logic [NCH-1:0] exp_out();
        logic [NCH-1:0] o;
        int pos;
        int sh;
        for (int i = 0; i < NCH; i++) begin
            sh = dhi[i] ? 0 : (dlo[i] ? 1 : 2);
            pos = ((cnt >> sh) - ph[i] * 64) & 255;
            o[i] = on_m[i] && (cf_m || fail_mode
                || pos < (gsel[i] ? gduty : duty[i]));
        end
        return o;
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask

    task automatic compare();
        chk(16'(output_drive), 16'(exp_out()));
        chk(16'(fast_edge), 16'(dhi));
        chk(16'(watchdog_toggle_bit), 16'(wd_m));
        chk(16'(clock_fail), 16'(cf_m));
    endtask

    task automatic apply(input logic [15:0] v);
        int c;
        int s;
        int d;
        a = v[15:12];
        wd_m = v[11];
        case (a)
            // sync only with bit one set
            1: if (v[1]) cnt = 0;
            2, 3, 4, 5, 6, 7: begin
                duty[a-2] = v[7:0];
                ph[a-2] = v[10:9];
                on_m[a-2] = v[8];
            end
            8: on_m = v[5:0];
            9: if (v[10]) gduty = v[7:0]; else gsel = v[5:0];
            12: if (v[10]) dhi = v[5:0]; else dlo = v[5:0];
            14: for (int i = 0; i < NINT; i++) begin
                c = v[2*i +: 2];
                s = (c == 0) ? 0 : 2 << c;
                d = v[10] ? duty[i] + s : duty[i] - s;
                duty[i] = d > 255 ? 255 : (d < 0 ? 0 : d);
            end
            default: ;
        endcase
    endtask

    // settings land after the frame ends
    task automatic frame(input logic [15:0] v, input logic whole);
        @(posedge pwm_clk_in);
        repeat (20) @(negedge core_clk);
        host.send(v, whole);
        repeat (8) @(negedge core_clk);
        if (whole) apply(v);
        compare();
    endtask

    task automatic rnd_frame();
        r = $random(seed);
        f = {4'(addrs[(r & 255) % 11]), r[31:20]};
        if (f[15:12] inside {[2:7]} || (f[15:12] == 9 && f[10]))
            f[7:0] = 8'(8 + r[19:8] % 240);
        frame(f, 1'b1);
    endtask

    task automatic conclude();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(negedge core_clk);
        resetn = 1'b1;
        @(negedge core_clk);
        compare();
        pwm_run = 1'b1;
        repeat (3) @(posedge pwm_clk_in);
        cf_m = 1'b0;
        frame(16'h1002, 1'b1);
        frame(16'h21F7, 1'b1);
        frame(16'h3108, 1'b1);
        frame(16'h7180, 1'b1);
        for (int c = 0; c < 4; c++) begin
            frame(16'hE400 | {5{2'(c)}}, 1'b1);
            frame(16'hE000 | {5{2'(c)}}, 1'b1);
        end
        // second down step meets the floor already reached
        for (int k = 0; k < 2; k++) frame(16'hE3FF, 1'b1);
        frame(16'h2100, 1'b0);
        for (int k = 0; k < 40; k++) rnd_frame();
        fail_mode = 1'b1;
        frame(16'h803F, 1'b1);
        fail_mode = 1'b0;
        pwm_run = 1'b0;
        repeat (1000) @(negedge core_clk);
        cf_m = 1'b1;
        compare();
        pwm_run = 1'b1;
        // first edge after the gap must not clear the failure
        @(posedge pwm_clk_in);
        repeat (8) @(negedge core_clk);
        compare();
        repeat (3) @(posedge pwm_clk_in);
        cf_m = 1'b0;
        frame(16'h1002, 1'b1);
        for (int k = 0; k < 10; k++) rnd_frame();
        conclude();
    end
endmodule
`default_nettype wire
